// file: adc_cfg_defines.vh
// Constants for the A/D converter configuration block.
// Contract
// - Reference bit: 0 supply, 1 external pin.
// - Clock field divides system clock by two-powers.
// - Pin0 enable set makes analog channel 0.
// - Pin1 enable set makes analog channel 1.
// - Channel 3 gives no usable conversion source.
`ifndef ADC_CFG_DEFINES_VH
`define ADC_CFG_DEFINES_VH
`define OFS_ADC_CONTROL_SECOND 4'h0
`define OFS_ANALOG_INPUT_ENABLE_LOW 4'h4
`define OFS_ADC_STATUS 4'h8
`define CTRL_WMASK 8'h17
`define ENAB_WMASK 8'h0F
`define CTRL_RESET 8'h00
`define ENAB_RESET 8'h0F
`define BIT_REF_SEL 4
`define DIV_MSB 2
`define DIV_LSB 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: adc_clk_divider.v
// Programmable power-of-two divider that makes the converter clock enable.
`timescale 1ns/1ps
module adc_clk_divider (
  input wire clk,
  input wire rst_b,
  input wire [2:0] sel,
  output reg tick,
  output wire valid
);
  reg [5:0] cnt_q;
  reg [5:0] limit;

  // Terminal count per setting; code 111 is undefined and gives no tick.
  always @* begin
    case (sel)
      3'h0: limit = 6'h00;
      3'h1: limit = 6'h01;
      3'h2: limit = 6'h03;
      3'h3: limit = 6'h07;
      3'h4: limit = 6'h0F;
      3'h5: limit = 6'h1F;
      3'h6: limit = 6'h3F;
      default: limit = 6'h3F;
    endcase
  end

  assign valid = (sel != 3'h7);

  // Free-running count; restarts when it reaches the limit so a setting change settles in one period.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 6'h00;
      tick <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q <= 6'h00;
      tick <= valid;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      tick <= 1'b0;
    end
  end
endmodule

// file: adc_ref_clock_input_select.v
// AXI4-Lite register block for A/D reference, clock divider and analog pin enables.
`timescale 1ns/1ps
`include "adc_cfg_defines.vh"
module adc_ref_clock_input_select (
  input wire CLK,
  input wire RST_B,
  input wire [3:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [3:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  output reg REFERENCE_SOURCE_SELECT,
  output reg [2:0] CONVERSION_CLOCK_DIVIDER,
  output reg ANALOG_CHANNEL0_EN,
  output reg ANALOG_CHANNEL1_EN,
  output reg ANALOG_ENABLE_PIN2,
  output reg ANALOG_CHANNEL3_EN,
  output reg CONV_CLK_TICK
);
  reg [7:0] ctrl_q;
  reg [7:0] enab_q;
  reg [3:0] awaddr_q;
  reg aw_have_q;
  reg [7:0] wdata_q;
  reg w_lane0_q;
  reg w_have_q;
  wire tick;
  wire div_valid;
  wire do_write;
  wire aw_take;
  wire w_take;
  wire ar_take;
  wire b_done;
  wire r_done;
  wire [3:0] wr_word;
  wire [3:0] rd_word;
  wire wr_known;
  wire rd_known;

  // Byte-lane merge of a write into the writable bits only.
  function [7:0] merge;
    input [7:0] old;
    input [7:0] data;
    input [7:0] mask;
    begin
      merge = (old & ~mask) | (data & mask);
    end
  endfunction

  // Word address of a byte address; the two low bits never select anything.
  function [3:0] word_of;
    input [3:0] addr;
    begin
      word_of = addr & 4'hC;
    end
  endfunction

  // True for the three decoded words, so both channels refuse the same holes.
  function known_word;
    input [3:0] word;
    begin
      case (word)
        `OFS_ADC_CONTROL_SECOND: known_word = 1'b1;
        `OFS_ANALOG_INPUT_ENABLE_LOW: known_word = 1'b1;
        `OFS_ADC_STATUS: known_word = 1'b1;
        default: known_word = 1'b0;
      endcase
    end
  endfunction

  // Response code for a decoded or an undecoded word.
  function [1:0] resp_of;
    input known;
    begin
      if (known) begin
        resp_of = `RESP_OKAY;
      end else begin
        resp_of = `RESP_SLVERR;
      end
    end
  endfunction

  // Address and data are latched independently so the master may present them in either order.
  assign S_AXI_AWREADY = !aw_have_q && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_have_q && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // One strobe per channel, true on the edge that moves an item.
  assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_take = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  assign b_done = S_AXI_BVALID && S_AXI_BREADY;
  assign r_done = S_AXI_RVALID && S_AXI_RREADY;

  // The write commits only when both halves are held and the previous answer has gone.
  assign do_write = aw_have_q && w_have_q && !S_AXI_BVALID;

  // Word decode shared by the write and the read channel.
  assign wr_word = word_of(awaddr_q);
  assign rd_word = word_of(S_AXI_ARADDR);
  assign wr_known = known_word(wr_word);
  assign rd_known = known_word(rd_word);

  // Write channel capture; a held half blocks its own channel until the master takes the write response.
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      awaddr_q <= 4'h0;
      aw_have_q <= 1'b0;
      wdata_q <= 8'h00;
      w_lane0_q <= 1'b0;
      w_have_q <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_q <= S_AXI_AWADDR;
        aw_have_q <= 1'b1;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (w_take) begin
        wdata_q <= S_AXI_WDATA[7:0];
        w_lane0_q <= S_AXI_WSTRB[0];
        w_have_q <= 1'b1;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response; it stands until the master takes it, which also reopens both write channels.
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= resp_of(wr_known);
    end else if (b_done) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Configuration registers; only byte lane 0 carries register bits, so other lanes are ignored.
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= `CTRL_RESET;
      enab_q <= `ENAB_RESET;
    end else if (do_write && w_lane0_q) begin
      case (wr_word)
        `OFS_ADC_CONTROL_SECOND: begin
          ctrl_q <= merge(ctrl_q, wdata_q, `CTRL_WMASK);
        end
        `OFS_ANALOG_INPUT_ENABLE_LOW: begin
          enab_q <= merge(enab_q, wdata_q, `ENAB_WMASK);
        end
        // Status and undecoded words leave every register as it is.
        default: begin
          ctrl_q <= ctrl_q;
          enab_q <= enab_q;
        end
      endcase
    end
  end

  // Read channel; status word shows the divider validity and tick so software sees live state.
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else if (ar_take) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= resp_of(rd_known);
      case (rd_word)
        `OFS_ADC_CONTROL_SECOND: begin
          S_AXI_RDATA <= {24'h000000, ctrl_q & `CTRL_WMASK};
        end
        `OFS_ANALOG_INPUT_ENABLE_LOW: begin
          S_AXI_RDATA <= {24'h000000, enab_q & `ENAB_WMASK};
        end
        `OFS_ADC_STATUS: begin
          S_AXI_RDATA <= {30'h00000000, div_valid, tick};
        end
        default: begin
          S_AXI_RDATA <= 32'h00000000;
        end
      endcase
    end else if (r_done) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  adc_clk_divider u_div (
    .clk(CLK),
    .rst_b(RST_B),
    .sel(ctrl_q[`DIV_MSB:`DIV_LSB]),
    .tick(tick),
    .valid(div_valid)
  );

  // Configuration outputs other than ANALOG_CHANNEL3_EN, which is held low, are registered copies so they change one cycle after the write.
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      REFERENCE_SOURCE_SELECT <= 1'b0;
      CONVERSION_CLOCK_DIVIDER <= 3'h0;
      ANALOG_CHANNEL0_EN <= 1'b1;
      ANALOG_CHANNEL1_EN <= 1'b1;
      ANALOG_ENABLE_PIN2 <= 1'b1;
      ANALOG_CHANNEL3_EN <= 1'b0;
      CONV_CLK_TICK <= 1'b0;
    end else begin
      REFERENCE_SOURCE_SELECT <= ctrl_q[`BIT_REF_SEL];
      CONVERSION_CLOCK_DIVIDER <= ctrl_q[`DIV_MSB:`DIV_LSB];
      ANALOG_CHANNEL0_EN <= enab_q[0];
      ANALOG_CHANNEL1_EN <= enab_q[1];
      ANALOG_ENABLE_PIN2 <= enab_q[2];
      ANALOG_CHANNEL3_EN <= 1'b0;
      CONV_CLK_TICK <= tick;
    end
  end
endmodule

// file: adc_cfg_monitor.sv
// Checker watching the ports of the A/D configuration block.
`timescale 1ns/1ps
module adc_cfg_monitor (
  input wire CLK,
  input wire RST_B,
  input wire S_AXI_BVALID,
  input wire S_AXI_RVALID,
  input wire [31:0] S_AXI_RDATA,
  input wire REFERENCE_SOURCE_SELECT,
  input wire [2:0] CONVERSION_CLOCK_DIVIDER,
  input wire ANALOG_CHANNEL0_EN,
  input wire ANALOG_CHANNEL1_EN,
  input wire ANALOG_CHANNEL3_EN,
  input wire CONV_CLK_TICK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Reference and channel 0/1 enables may only move within three cycles of a write response.
  AST_REF_WR:
  assert property ($changed(REFERENCE_SOURCE_SELECT) |-> $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2)
    || $past(S_AXI_BVALID, 3)) else $error("reference moved without a write");
  AST_EN_WR:
  assert property ($changed({ANALOG_CHANNEL0_EN, ANALOG_CHANNEL1_EN}) |-> $past(S_AXI_BVALID)
    || $past(S_AXI_BVALID, 2) || $past(S_AXI_BVALID, 3)) else $error("pin enable moved without a write");
  // A setled divider of one pulses every cycle, the spare code never.
  AST_DIV0_TICK:
  assert property ((CONVERSION_CLOCK_DIVIDER == 3'h0) [*4] |-> CONV_CLK_TICK) else $error("tick missing");
  AST_DIV7_IDLE:
  assert property ((CONVERSION_CLOCK_DIVIDER == 3'h7) [*8] |-> !CONV_CLK_TICK) else $error("tick on code 7");
  AST_CH3_OFF:
  assert property (!ANALOG_CHANNEL3_EN) else $error("unbonded channel enabled");
  AST_RD_HIGH_ZERO:
  assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:5] == 27'h0) else $error("unused read bits set");
endmodule

// file: test_adc_ref_clock_input_select.sv
// Self-checking bench for the A/D configuration block.
`timescale 1ns/1ps
module test_adc_ref_clock_input_select;
  reg clk, rst_b, awv, wv, bry, arv, rry, ta, tw, tb;
  reg [3:0] aw, ar;
  reg [31:0] wd, rd_v;
  reg [3:0] ws;
  reg [1:0] br;
  wire awr, wrd, bv, arr, rv, refs, ch0, ch1, pin2, ch3, tick;
  wire [1:0] rresp, bresp;
  wire [2:0] div;
  wire [31:0] rdat;
  integer error_cnt, samples_checked, n, s;
  adc_ref_clock_input_select u_adc_ref_clock_input_select (.CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(aw),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ar),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .REFERENCE_SOURCE_SELECT(refs), .CONVERSION_CLOCK_DIVIDER(div),
    .ANALOG_CHANNEL0_EN(ch0), .ANALOG_CHANNEL1_EN(ch1), .ANALOG_ENABLE_PIN2(pin2),
    .ANALOG_CHANNEL3_EN(ch3), .CONV_CLK_TICK(tick));
  // Compares one value and counts it.
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Write; handshakes are judged at the falling edge, since nothing moves until the next rising one.
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      aw <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      tb = 1'h0;
      while (!tb) begin
        @(negedge clk);
        ta = awv & awr;
        tw = wv & wrd;
        tb = bv;
        br = bresp;
        @(posedge clk);
        if (ta) awv <= 1'h0;
        if (tw) wv <= 1'h0;
      end
      bry <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  // Read into rd_v, holding the address until it is taken.
  task rd(input [3:0] a);
    begin
      @(posedge clk);
      ar <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      tb = 1'h0;
      while (!tb) begin
        @(negedge clk);
        ta = arv & arr;
        tb = rv;
        rd_v = rdat;
        @(posedge clk);
        if (ta) arv <= 1'h0;
      end
      rry <= 1'h0;
    end
  endtask
  task t_ref;
    begin
      wr(4'h0, 32'hFF);
      rd(4'h0);
      chk("ctrl", 32'h17, rd_v);
      chk("ref", 32'h1, refs);
      wr(4'h0, 32'h0);
      chk("ref", 32'h0, refs);
    end
  endtask
  // Every divider code, counting pulses over 128 cycles.
  task t_div;
    for (s = 0; s < 8; s = s + 1) begin
      wr(4'h0, s);
      n = 0;
      repeat (128) begin
        @(negedge clk);
        n = n + tick;
      end
      chk("ticks", (s == 7) ? 0 : 128 >> s, n);
      if (s == 0 || s == 7) begin
        rd(4'h8);
        chk("status", (s == 0) ? 3 : 0, rd_v);
      end
    end
  endtask
  task t_enab;
    begin
      rd(4'h4);
      chk("enab", 32'hF, rd_v);
      wr(4'h4, 32'hFA);
      rd(4'h4);
      chk("enab", 32'hA, rd_v);
      chk("pins", 32'h2, {pin2, ch1, ch0});
      @(posedge clk);
      ws <= 4'hE;
      wr(4'h4, 32'hF);
      rd(4'h4);
      chk("strobe", 32'hA, rd_v);
      @(posedge clk);
      ws <= 4'hF;
      wr(4'h4, 32'h9);
      chk("pins", 32'h2, {pin2, ch1, ch0, ch3});
      rd(4'hC);
      chk("resp", 32'h2, rresp);
      wr(4'hC, 32'h0);
      chk("bresp", 32'h2, br);
      wr(4'h8, 32'hFF);
      chk("bresp", 32'h0, br);
      wr(4'h4, 32'hF);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // Clock of 4 ns.
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Main sequence after two reset cycles.
  initial begin
    {error_cnt, samples_checked} = 0;
    {rst_b, awv, wv, bry, arv, rry, aw, ar, wd} = 0;
    ws = 4'hF;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    t_enab;
    t_ref;
    t_div;
    give_verdict;
  end
  // The run needs about 5 us; this cuts a hang.
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
endmodule
bind adc_ref_clock_input_select adc_cfg_monitor u_adc_cfg_monitor (.CLK, .RST_B, .S_AXI_BVALID, .S_AXI_RVALID,
  .S_AXI_RDATA, .REFERENCE_SOURCE_SELECT, .CONVERSION_CLOCK_DIVIDER, .ANALOG_CHANNEL0_EN, .ANALOG_CHANNEL1_EN,
  .ANALOG_CHANNEL3_EN, .CONV_CLK_TICK);
